// file: hdl/ocrb_bank.sv
// Option and control register bank, nibble registers 0x6F to 0x7F plus interrupt pair.
// Assumes a single-cycle CPU register port on mclk and a level detector driving pins.
//
// The plain strobed port is this design's own decision.
`include "ocrb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ocrb_bank
    import ocrb_pkg::*;
#(
    parameter int RAM_ENTRIES = `OCRB_RAM_ENTRIES
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       porReset,
    input  wire ocrb_req_t  busReq,
    output logic [3:0]      rdata,
    input  wire logic [3:0] indexLow,
    output logic [6:0]      indexPointer,
    output ocrb_seg_t       segmentAccess,
    input  wire logic [3:0] segmentRdata,
    output ocrb_opt_t       options,
    output ocrb_lcd_t       displayControl,
    output logic [1:0]      watchdogDisable,
    output logic [2:0]      detectorThreshold,
    output logic            levelDetectorStart,
    input  wire logic       detectorBusyPin,
    input  wire logic       detectorResultPin,
    output logic            irq
);
    logic [2:0]  index_pointer_high_r;
    logic [1:0]  lcdCsHi_r;
    logic [1:0]  lcdCsLo_r;
    logic [2:0]  lcdMnHi_r;
    logic        lcdMnLo_r;
    logic [1:0]  vldWd_r;
    logic [2:0]  vldThr_r;
    ocrb_opt_t   opt_r;
    logic [3:0]  ram_r [RAM_ENTRIES];
    logic [3:0]  rdata_r;
    logic        measure_r;
    logic        startPulse_r;
    logic [2:0]  busySync_r;
    logic [2:0]  resultSync_r;
    logic        busyFilt_r;
    logic        resultFilt_r;
    logic        busyPrev_r;
    logic [1:0]  irqStat_r;
    logic [1:0]  irqMask_r;
    logic [1:0]  irqStat_nxt;
    logic [3:0]  readMux;
    logic [3:0]  windowRead;

    wire wrEn = busReq.wr;
    wire rdEn = busReq.rd;
    wire [7:0] addr = busReq.addr;
    wire [3:0] wd = busReq.wdata;
    wire [6:0] index = {index_pointer_high_r, indexLow};
    wire inRam = (index < 7'(RAM_ENTRIES));
    wire wrIxHigh = wrEn && (addr == `OCRB_A_IX_HIGH);
    wire wrWindow = wrEn && (addr == `OCRB_A_WINDOW);
    wire wrLcdCs = wrEn && (addr == `OCRB_A_LCD_CLKSTB);
    wire wrLcdMn = wrEn && (addr == `OCRB_A_LCD_MAIN);
    wire wrVld = wrEn && (addr == `OCRB_A_VLD_CTRL);
    wire wrThr = wrEn && (addr == `OCRB_A_VLD_THR);
    wire wrStat = wrEn && (addr == `OCRB_A_IRQ_STAT);
    wire wrMask = wrEn && (addr == `OCRB_A_IRQ_MASK);
    wire startReq = wrVld && wd[`OCRB_VLD_START_BIT];
    wire measureDone = busyPrev_r && !busyFilt_r;
    wire [1:0] irqEvent = {measureDone && resultFilt_r, measureDone};

    // Window accesses above the RAM area go to the display segment memory.
    assign windowRead = inRam ? ram_r[index[5:0]] : segmentRdata;
    assign segmentAccess.write = wrWindow && !inRam;
    assign segmentAccess.addr = index[5:0];
    assign segmentAccess.data = wd;

    // Read selection; unmapped, reserved and test addresses read zero.
    always_comb begin
        unique case (addr)
            `OCRB_A_IX_HIGH:    readMux = {1'b0, index_pointer_high_r};
            `OCRB_A_WINDOW:     readMux = windowRead;
            `OCRB_A_LCD_CLKSTB: readMux = {lcdCsHi_r, lcdCsLo_r};
            `OCRB_A_LCD_MAIN:   readMux = {lcdMnHi_r, lcdMnLo_r};
            `OCRB_A_VLD_CTRL:   readMux = {resultFilt_r, measure_r, vldWd_r};
            `OCRB_A_VLD_THR:    readMux = {1'b0, vldThr_r};
            `OCRB_A_DEB_BYP:    readMux = opt_r.debounceBypass;
            `OCRB_A_EDGE_SEL:   readMux = opt_r.edgeSelect;
            `OCRB_A_PA_NOPD:    readMux = opt_r.portAPulldownOff;
            `OCRB_A_PB_NOPD:    readMux = opt_r.portBPulldownOff;
            `OCRB_A_PB_OPDR:    readMux = opt_r.portBOpenDrain;
            `OCRB_A_SP_OPDR:    readMux = opt_r.serialOpenDrain;
            `OCRB_A_FOUT_WAKE:  readMux = opt_r.freqOutWake;
            `OCRB_A_CRES_1:     readMux = opt_r.comboReset1;
            `OCRB_A_CRES_2:     readMux = opt_r.comboReset2;
            `OCRB_A_SP_NOPD:    readMux = opt_r.serialPulldownOff;
            `OCRB_A_IRQ_STAT:   readMux = {2'h0, irqStat_r};
            `OCRB_A_IRQ_MASK:   readMux = {2'h0, irqMask_r};
            default:            readMux = 4'h0;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (reset || porReset) begin
            rdata_r <= 4'h0;
        end else begin
            rdata_r <= rdEn ? readMux : 4'h0;
        end
    end

    // Option registers ignore the system reset and clear only on power-on.
    always_ff @(posedge mclk) begin
        if (porReset) begin
            opt_r <= '0;
        end else if (wrEn) begin
            unique case (addr)
                `OCRB_A_DEB_BYP:   opt_r.debounceBypass <= wd;
                `OCRB_A_EDGE_SEL:  opt_r.edgeSelect <= wd;
                `OCRB_A_PA_NOPD:   opt_r.portAPulldownOff <= wd;
                `OCRB_A_PB_NOPD:   opt_r.portBPulldownOff <= wd;
                `OCRB_A_PB_OPDR:   opt_r.portBOpenDrain <= wd;
                `OCRB_A_SP_OPDR:   opt_r.serialOpenDrain <= wd;
                `OCRB_A_FOUT_WAKE: opt_r.freqOutWake <= wd;
                `OCRB_A_CRES_1:    opt_r.comboReset1 <= wd;
                `OCRB_A_CRES_2:    opt_r.comboReset2 <= wd;
                `OCRB_A_SP_NOPD:   opt_r.serialPulldownOff <= wd;
                default:           opt_r <= opt_r;
            endcase
        end
    end

    // Bits defined by power-on keep their value over the other resets.
    always_ff @(posedge mclk) begin
        if (porReset) begin
            index_pointer_high_r  <= `OCRB_RST_IX_HIGH;
            lcdCsHi_r <= 2'(`OCRB_RST_LCD_CS_POR >> 2);
            lcdMnLo_r <= 1'(`OCRB_RST_LCD_MN_POR & 4'h1);
        end else begin
            if (wrIxHigh) begin
                index_pointer_high_r <= wd[2:0];
            end
            if (wrLcdCs) begin
                lcdCsHi_r <= wd[3:2];
            end
            if (wrLcdMn) begin
                lcdMnLo_r <= wd[0];
            end
        end
    end

    // Control bits cleared or set by every reset.
    always_ff @(posedge mclk) begin
        if (reset || porReset) begin
            lcdCsLo_r <= `OCRB_RST_LCD_CS_LO;
            lcdMnHi_r <= `OCRB_RST_LCD_MN_HI;
            vldWd_r   <= `OCRB_RST_VLD_WD;
            vldThr_r  <= `OCRB_RST_VLD_THR;
        end else begin
            if (wrLcdCs) begin
                lcdCsLo_r <= wd[1:0];
            end
            if (wrLcdMn) begin
                lcdMnHi_r <= wd[3:1];
            end
            if (wrVld) begin
                vldWd_r <= wd[1:0];
            end
            if (wrThr) begin
                vldThr_r <= wd[2:0];
            end
        end
    end

    // Indexed RAM, one nibble per entry, cleared by reset.
    for (genvar i = 0; i < RAM_ENTRIES; i++) begin : g_ram
        always_ff @(posedge mclk) begin
            if (reset || porReset) begin
                ram_r[i] <= 4'h0;
            end else if (wrWindow && inRam && (index[5:0] == 6'(i))) begin
                ram_r[i] <= wd;
            end
        end
    end

    // Detector pins pass three flops; a change counts when the last two agree.
    always_ff @(posedge mclk) begin
        busySync_r   <= {busySync_r[1:0], detectorBusyPin};
        resultSync_r <= {resultSync_r[1:0], detectorResultPin};
        if (reset || porReset) begin
            busyFilt_r   <= 1'b0;
            resultFilt_r <= 1'b0;
            busyPrev_r   <= 1'b0;
        end else begin
            if (busySync_r[1] == busySync_r[2]) begin
                busyFilt_r <= busySync_r[2];
            end
            if (resultSync_r[1] == resultSync_r[2]) begin
                resultFilt_r <= resultSync_r[2];
            end
            busyPrev_r <= busyFilt_r;
        end
    end

    // Busy from the start write until the detector finishes; a new start wins.
    always_ff @(posedge mclk) begin
        if (reset || porReset) begin
            measure_r    <= 1'b0;
            startPulse_r <= 1'b0;
        end else begin
            measure_r    <= startReq || (measure_r && !measureDone);
            startPulse_r <= startReq;
        end
    end

    // Sticky events: set wins over a write-one clear.
    assign irqStat_nxt = (irqStat_r & ~(wrStat ? wd[1:0] : 2'h0)) | irqEvent;
    always_ff @(posedge mclk) begin
        if (reset || porReset) begin
            irqStat_r <= `OCRB_RST_IRQ;
            irqMask_r <= `OCRB_RST_IRQ;
        end else begin
            irqStat_r <= irqStat_nxt;
            if (wrMask) begin
                irqMask_r <= wd[1:0];
            end
        end
    end

    assign rdata = rdata_r;
    assign indexPointer = index;
    assign options = opt_r;
    assign displayControl = {lcdCsLo_r, lcdCsHi_r, lcdMnLo_r, lcdMnHi_r[0],
                             lcdMnHi_r[1], lcdMnHi_r[2]};
    assign watchdogDisable = vldWd_r;
    assign detectorThreshold = vldThr_r;
    assign levelDetectorStart = startPulse_r;
    assign irq = |(irqStat_r & irqMask_r);

    sequence s_read(logic [7:0] a);
        busReq.rd && busReq.addr == a;
    endsequence

    sequence s_window_write_then_read;
        (wrWindow && inRam) ##1 (s_read(`OCRB_A_WINDOW) && $stable(index));
    endsequence

    a_opt_por_clear: assert property (@(posedge mclk)
        porReset |=> options == '0)
        else $error("options not cleared by power-on reset");
    a_opt_keep_reset: assert property (@(posedge mclk)
        (reset && !porReset && !busReq.wr) |=> $stable(options))
        else $error("options changed by system reset");
    a_ixh_top_zero: assert property (@(posedge mclk) disable iff (reset || porReset)
        s_read(`OCRB_A_IX_HIGH) |=> rdata[3] == 1'b0)
        else $error("index high bit 3 not zero");
    a_window_ram_data: assert property (@(posedge mclk) disable iff (reset || porReset)
        s_window_write_then_read |=> rdata == $past(busReq.wdata, 2))
        else $error("window read differs from last write");
    a_lcd_cs_por: assert property (@(posedge mclk)
        porReset |=> {displayControl.strobeOutputSelect,
                      displayControl.multiplierClockSelect} == 4'hC)
        else $error("display clock strobe power-on value wrong");
    a_lcd_main_reset: assert property (@(posedge mclk)
        (reset && !porReset) |=> {displayControl.blank, displayControl.powerOff,
                                  displayControl.fourWayMux} == 3'h7)
        else $error("display main reset value wrong");
    a_vld_busy_read: assert property (@(posedge mclk) disable iff (reset || porReset)
        s_read(`OCRB_A_VLD_CTRL) |=> rdata[2] == $past(measure_r))
        else $error("detector busy read wrong");
    a_vld_start_busy: assert property (@(posedge mclk) disable iff (reset || porReset)
        startReq |=> levelDetectorStart && measure_r ##1 !levelDetectorStart)
        else $error("start did not raise busy and one pulse");
    a_thr_top_zero: assert property (@(posedge mclk) disable iff (reset || porReset)
        s_read(`OCRB_A_VLD_THR) |=> rdata[3] == 1'b0)
        else $error("threshold bit 3 not zero");
    a_deb_write_take: assert property (@(posedge mclk) disable iff (porReset)
        (busReq.wr && busReq.addr == `OCRB_A_DEB_BYP)
        |=> options.debounceBypass == $past(busReq.wdata))
        else $error("debounce bypass write lost");
    a_test_read_zero: assert property (@(posedge mclk) disable iff (reset || porReset)
        s_read(`OCRB_A_TEST) |=> rdata == 4'h0)
        else $error("test location read not zero");
endmodule : ocrb_bank
`default_nettype wire

// file: hdl/ocrb_cfg.svh
// Constants of the option and control register bank.
// Assumes an 8-bit nibble register address; no other file defines these names.
`ifndef OCRB_CFG_SVH
`define OCRB_CFG_SVH
`define OCRB_ADDR_W         8
`define OCRB_A_IX_HIGH      8'h6F
`define OCRB_A_WINDOW       8'h70
`define OCRB_A_LCD_CLKSTB   8'h71
`define OCRB_A_LCD_MAIN     8'h72
`define OCRB_A_VLD_CTRL     8'h73
`define OCRB_A_VLD_THR      8'h74
`define OCRB_A_DEB_BYP      8'h75
`define OCRB_A_EDGE_SEL     8'h76
`define OCRB_A_PA_NOPD      8'h77
`define OCRB_A_PB_NOPD      8'h78
`define OCRB_A_PB_OPDR      8'h79
`define OCRB_A_SP_OPDR      8'h7A
`define OCRB_A_FOUT_WAKE    8'h7B
`define OCRB_A_CRES_1       8'h7C
`define OCRB_A_CRES_2       8'h7D
`define OCRB_A_SP_NOPD      8'h7E
`define OCRB_A_TEST         8'h7F
`define OCRB_A_IRQ_STAT     8'h80
`define OCRB_A_IRQ_MASK     8'h81
`define OCRB_RST_IX_HIGH    3'h0
`define OCRB_RST_OPTION     4'h0
`define OCRB_RST_LCD_CS_POR 4'hC
`define OCRB_RST_LCD_CS_LO  2'h0
`define OCRB_RST_LCD_MN_POR 4'hF
`define OCRB_RST_LCD_MN_HI  3'h7
`define OCRB_RST_VLD_WD     2'h0
`define OCRB_RST_VLD_THR    3'h0
`define OCRB_RST_IRQ        2'h0
`define OCRB_VLD_START_BIT  2
`define OCRB_RAM_ENTRIES    64
`endif

// file: hdl/ocrb_pkg.sv
// Types of the option and control register bank.
// Assumes ocrb_cfg.svh is on the include path.
package ocrb_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } ocrb_req_t;

    typedef struct packed {
        logic [3:0] debounceBypass;
        logic [3:0] edgeSelect;
        logic [3:0] portAPulldownOff;
        logic [3:0] portBPulldownOff;
        logic [3:0] portBOpenDrain;
        logic [3:0] serialOpenDrain;
        logic [3:0] freqOutWake;
        logic [3:0] comboReset1;
        logic [3:0] comboReset2;
        logic [3:0] serialPulldownOff;
    } ocrb_opt_t;

    typedef struct packed {
        logic [1:0] multiplierClockSelect;
        logic [1:0] strobeOutputSelect;
        logic       externalSupply;
        logic       fourWayMux;
        logic       powerOff;
        logic       blank;
    } ocrb_lcd_t;

    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic [3:0] data;
    } ocrb_seg_t;
endpackage : ocrb_pkg

// file: test/tb.sv
// Self-checking testbench of the option and control register bank.
// Assumes ocrb_cfg.svh on the include path and ocrb_pkg compiled before this file.
`include "ocrb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ocrb_pkg::*;
    logic       mclk              = 1'b0;
    logic       reset             = 1'b1;
    logic       porReset          = 1'b1;
    ocrb_req_t  busReq            = '0;
    logic [3:0] indexLow          = 4'h0;
    logic [3:0] segmentRdata      = 4'h0;
    logic       detectorBusyPin   = 1'b0;
    logic       detectorResultPin = 1'b0;
    logic [3:0] rdata;
    logic [6:0] indexPointer;
    ocrb_seg_t  segmentAccess;
    ocrb_opt_t  options;
    ocrb_lcd_t  displayControl;
    logic [1:0] watchdogDisable;
    logic [2:0] detectorThreshold;
    logic       levelDetectorStart;
    logic       irq;
    logic [3:0] regExp [16];
    logic [3:0] ramExp [64];
    int         n_errors          = 0;
    int         check_count       = 0;

    always #25 mclk = ~mclk;

    ocrb_bank ocrb_bank_i (.mclk(mclk), .reset(reset), .porReset(porReset), .busReq(busReq),
        .rdata(rdata), .indexLow(indexLow), .indexPointer(indexPointer),
        .segmentAccess(segmentAccess), .segmentRdata(segmentRdata), .options(options),
        .displayControl(displayControl), .watchdogDisable(watchdogDisable),
        .detectorThreshold(detectorThreshold), .levelDetectorStart(levelDetectorStart),
        .detectorBusyPin(detectorBusyPin), .detectorResultPin(detectorResultPin), .irq(irq));

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    function automatic logic [6:0] idx();
        return {regExp[0][2:0], indexLow};
    endfunction : idx

    function automatic logic [3:0] expRead(input logic [7:0] a);
        logic [6:0] i;
        i = idx();
        if (a == `OCRB_A_WINDOW) return i[6] ? segmentRdata : ramExp[i[5:0]];
        if (a >= `OCRB_A_IX_HIGH && a <= `OCRB_A_SP_NOPD) return regExp[a - `OCRB_A_IX_HIGH];
        return 4'h0;
    endfunction : expRead

    function automatic ocrb_opt_t optExp();
        logic [39:0] v;
        for (int k = 0; k < 10; k++) v[36 - 4 * k +: 4] = regExp[k + 6];
        return ocrb_opt_t'(v);
    endfunction : optExp

    function automatic ocrb_lcd_t lcdExp();
        return {regExp[2][1:0], regExp[2][3:2], regExp[3][0], regExp[3][1], regExp[3][2],
                regExp[3][3]};
    endfunction : lcdExp

    task automatic doReset(input logic por);
        reset <= 1'b1;
        porReset <= por;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        porReset <= 1'b0;
        for (int k = 0; k < 64; k++) ramExp[k] = 4'h0;
        regExp[2] = regExp[2] & 4'hC;
        regExp[3] = regExp[3] | 4'hE;
        regExp[4] = 4'h0;
        regExp[5] = 4'h0;
        if (por) begin
            for (int k = 0; k < 16; k++) regExp[k] = 4'h0;
            regExp[2] = 4'hC;
            regExp[3] = 4'hF;
        end
    endtask : doReset

    task automatic wrReg(input logic [7:0] a, input logic [3:0] d);
        logic [6:0] i;
        @(posedge mclk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        #1;
        i = idx();
        if (a == `OCRB_A_WINDOW && i[6]) check(segmentAccess, {1'b1, i[5:0], d});
        else check(segmentAccess.write, 1'b0);
        @(posedge mclk);
        busReq.wr <= 1'b0;
        if (a == `OCRB_A_WINDOW) begin
            if (!i[6]) ramExp[i[5:0]] = d;
        end else if (a >= `OCRB_A_IX_HIGH && a <= `OCRB_A_SP_NOPD) begin
            regExp[a - `OCRB_A_IX_HIGH] = d & ((a == `OCRB_A_IX_HIGH || a == `OCRB_A_VLD_THR)
                ? 4'h7 : (a == `OCRB_A_VLD_CTRL) ? 4'h3 : 4'hF);
        end
    endtask : wrReg

    task automatic rdReg(input logic [7:0] a, output logic [3:0] v);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1 v = rdata;
    endtask : rdReg

    task automatic checkAll();
        logic [3:0] v;
        check(options, optExp());
        check(displayControl, lcdExp());
        check(watchdogDisable, regExp[4][1:0]);
        check(detectorThreshold, regExp[5][2:0]);
        check(indexPointer, idx());
        for (logic [7:0] a = 8'h6F; a <= 8'h7F; a++) begin
            rdReg(a, v);
            check(v, expRead(a));
        end
    endtask : checkAll

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        end_sim();
    end

    initial begin
        logic [7:0] a;
        logic [3:0] d;
        logic [3:0] v;
        void'($urandom(86));
        doReset(1'b1);
        checkAll();
        $display("Test reset values done");
        for (int n = 0; n < 60; n++) begin
            a = 8'h6F + 8'($urandom % 17);
            d = 4'($urandom);
            if (a == `OCRB_A_VLD_CTRL) d = d & 4'h3;
            indexLow <= 4'($urandom);
            segmentRdata <= 4'($urandom);
            wrReg(a, d);
            rdReg(a, v);
            check(v, expRead(a));
            check(options, optExp());
            check(displayControl, lcdExp());
            if (n % 20 == 19) checkAll();
        end
        wrReg(8'h90, 4'hF);
        wrReg(8'h6E, 4'hF);
        rdReg(8'h90, v);
        check(v, 4'h0);
        $display("Test random access done");
        for (logic [7:0] k = 8'h6F; k <= 8'h7E; k++) wrReg(k, (k == 8'h73) ? 4'h3 : 4'hF);
        doReset(1'b0);
        checkAll();
        doReset(1'b1);
        checkAll();
        $display("Test reset kinds done");
        wrReg(`OCRB_A_IRQ_MASK, 4'h0);
        wrReg(`OCRB_A_VLD_CTRL, 4'h5);
        #1 check(levelDetectorStart, 1'b1);
        @(posedge mclk);
        #1 check(levelDetectorStart, 1'b0);
        rdReg(`OCRB_A_VLD_CTRL, v);
        check(v[2:0], 3'h5);
        detectorResultPin <= 1'b1;
        detectorBusyPin <= 1'b1;
        repeat (6) @(posedge mclk);
        rdReg(`OCRB_A_VLD_CTRL, v);
        check(v[2:0], 3'h5);
        detectorBusyPin <= 1'b0;
        repeat (10) @(posedge mclk);
        rdReg(`OCRB_A_VLD_CTRL, v);
        check(v, 4'h9);
        rdReg(`OCRB_A_IRQ_STAT, v);
        check(v, 4'h3);
        check(irq, 1'b0);
        wrReg(`OCRB_A_IRQ_MASK, 4'h2);
        #1 check(irq, 1'b1);
        wrReg(`OCRB_A_IRQ_STAT, 4'h2);
        #1 check(irq, 1'b0);
        wrReg(`OCRB_A_IRQ_MASK, 4'h3);
        #1 check(irq, 1'b1);
        wrReg(`OCRB_A_IRQ_STAT, 4'h1);
        #1 check(irq, 1'b0);
        rdReg(`OCRB_A_IRQ_STAT, v);
        check(v, 4'h0);
        @(posedge mclk);
        busReq <= '{addr: `OCRB_A_WINDOW, wdata: 4'hA, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq <= '{addr: `OCRB_A_WINDOW, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1 check(rdata, 4'hA);
        $display("Test detector and interrupt done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
